// file: hw/digital_pot_wiper_control.sv
// Purpose: wiper code registers, shutdown control and command execution
// Assumes: host keeps cs_n high at least 40 ns and sck still outside frames
// Notes: wiper tap 0 is terminal B, tap 256 would be terminal A
module digital_pot_wiper_control import pot_pkg::*; (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  output logic so,
  // hardware controls
  input wire logic midscale_reset_n,
  input wire logic hw_powerdown_n,
  // channel 0
  output logic [CODE_W-1:0] chan0_code,
  output logic [TAP_W-1:0] chan0_wiper,
  output logic chan0_term_a,
  output logic chan0_term_b,
  // channel 1
  output logic [CODE_W-1:0] chan1_code,
  output logic [TAP_W-1:0] chan1_wiper,
  output logic chan1_term_a,
  output logic chan1_term_b,
  // status
  output logic frame_abort
);
  function automatic logic chan_sel(input logic [FRAME_BITS-1:0] w, input int idx);
    chan_sel = w[CH0_BIT + idx];
  endfunction

  function automatic logic [1:0] cmd_of(input logic [FRAME_BITS-1:0] w);
    cmd_of = {w[CMD_HI_BIT], w[CMD_LO_BIT]};
  endfunction

  logic [FRAME_BITS-1:0] link_word;
  logic link_ok;
  logic link_tog;

  pot_serial_link u_pot_serial_link (
    .nrst(nrst),
    .sck(sck),
    .cs_n(cs_n),
    .sdi(sdi),
    .so(so),
    .word(link_word),
    .word_ok(link_ok),
    .frame_tog(link_tog)
  );

  // synchronisers for pins and the link toggle
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic mr_s1_reg, mr_s2_reg;
  logic pd_s1_reg, pd_s2_reg;
  logic tog_s1_reg, tog_s2_reg, tog_seen_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      mr_s1_reg <= 1'b1;
      mr_s2_reg <= 1'b1;
      pd_s1_reg <= 1'b1;
      pd_s2_reg <= 1'b1;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      mr_s1_reg <= midscale_reset_n;
      mr_s2_reg <= mr_s1_reg;
      pd_s1_reg <= hw_powerdown_n;
      pd_s2_reg <= pd_s1_reg;
      tog_s1_reg <= link_tog;
      tog_s2_reg <= tog_s1_reg;
    end
  end

  wire cs_rise;
  wire new_frame;
  wire mid_reset;
  wire hw_down;
  assign cs_rise = cs_s2_reg & ~cs_s3_reg;
  assign new_frame = tog_s2_reg ^ tog_seen_reg;
  assign mid_reset = ~mr_s2_reg;
  assign hw_down = ~pd_s2_reg;

  // command capture: word is stable while cs_n is high
  exec_state_t state_reg, state_next;
  logic [FRAME_BITS-1:0] cmd_word_reg;
  logic cmd_valid_reg;
  logic abort_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cs_rise) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cmd_word_reg <= WORD_RST;
      cmd_valid_reg <= 1'b0;
      tog_seen_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && cs_rise) begin
        cmd_word_reg <= link_word;
        cmd_valid_reg <= new_frame & link_ok;
        abort_reg <= new_frame & ~link_ok;
        tog_seen_reg <= tog_s2_reg;
      end
    end
  end

  wire exec_cycle;
  wire exec_write;
  wire exec_shut;
  wire [CODE_W-1:0] cmd_data;
  assign exec_cycle = (state_reg == ST_EXEC) & cmd_valid_reg;
  assign exec_write = exec_cycle & (cmd_of(cmd_word_reg) == CMD_WRITE);
  assign exec_shut = exec_cycle & (cmd_of(cmd_word_reg) == CMD_SHUT);
  assign cmd_data = cmd_word_reg[DATA_MSB:DATA_LSB];

  // per-channel code and software shutdown
  logic [CODE_W-1:0] code_reg [N_CHAN];
  logic [CODE_W-1:0] code_next [N_CHAN];
  logic [N_CHAN-1:0] sw_shut_reg, sw_shut_next;
  logic [N_CHAN-1:0] shut_next;
  logic [TAP_W-1:0] tap_reg [N_CHAN];
  logic [TAP_W-1:0] tap_next [N_CHAN];
  logic [N_CHAN-1:0] term_a_reg;
  logic [N_CHAN-1:0] term_b_reg;

  always_comb begin
    for (int i = 0; i < N_CHAN; i++) begin
      code_next[i] = code_reg[i];
      sw_shut_next[i] = sw_shut_reg[i];
      if (mid_reset) begin
        code_next[i] = MID_CODE;
        sw_shut_next[i] = 1'b0;
      end else if (exec_write && chan_sel(cmd_word_reg, i)) begin
        code_next[i] = cmd_data;
        sw_shut_next[i] = 1'b0;
      end else if (exec_shut && chan_sel(cmd_word_reg, i)) begin
        sw_shut_next[i] = 1'b1;
      end
      shut_next[i] = sw_shut_next[i] | hw_down;
      // tap equals code, so top code lands one step below A
      tap_next[i] = shut_next[i] ? TAP_B_END : {1'b0, code_next[i]};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < N_CHAN; i++) begin
        code_reg[i] <= MID_CODE;
        tap_reg[i] <= {1'b0, MID_CODE};
      end
      sw_shut_reg <= '0;
      term_a_reg <= '1;
      term_b_reg <= '0;
    end else begin
      for (int i = 0; i < N_CHAN; i++) begin
        code_reg[i] <= code_next[i];
        tap_reg[i] <= tap_next[i];
      end
      sw_shut_reg <= sw_shut_next;
      term_a_reg <= ~shut_next;
      term_b_reg <= shut_next;
    end
  end

  assign chan0_code = code_reg[0];
  assign chan1_code = code_reg[1];
  assign chan0_wiper = tap_reg[0];
  assign chan1_wiper = tap_reg[1];
  assign chan0_term_a = term_a_reg[0];
  assign chan1_term_a = term_a_reg[1];
  assign chan0_term_b = term_b_reg[0];
  assign chan1_term_b = term_b_reg[1];
  assign frame_abort = abort_reg;

  // checks
  property p_midscale;
    @(posedge clk_sys) disable iff (!nrst)
    mid_reset |=> (chan0_code == MID_CODE) && (chan1_code == MID_CODE);
  endproperty
  a_midscale: assert property (p_midscale) else $error("reset did not give mid-scale");

  property p_powerdown;
    @(posedge clk_sys) disable iff (!nrst)
    hw_down |=> !chan0_term_a && !chan1_term_a && chan0_term_b && chan1_term_b;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("powerdown left A connected");

  property p_shut_keeps_code;
    @(posedge clk_sys) disable iff (!nrst)
    hw_down && !mid_reset && !exec_write |=> $stable(chan0_code) && chan0_wiper == TAP_B_END;
  endproperty
  a_shut_keeps_code: assert property (p_shut_keeps_code) else $error("code not kept");

  property p_zero_at_b;
    @(posedge clk_sys) disable iff (!nrst)
    chan0_term_a && chan0_code == ZERO_CODE |-> chan0_wiper == TAP_B_END;
  endproperty
  a_zero_at_b: assert property (p_zero_at_b) else $error("code zero not at B");

  property p_tap_follows;
    @(posedge clk_sys) disable iff (!nrst)
    chan1_term_a |-> chan1_wiper == {1'b0, chan1_code};
  endproperty
  a_tap_follows: assert property (p_tap_follows) else $error("tap not equal to code");

  property p_never_a;
    @(posedge clk_sys) disable iff (!nrst)
    chan0_wiper != TAP_A_END && chan1_wiper != TAP_A_END;
  endproperty
  a_never_a: assert property (p_never_a) else $error("wiper reached terminal A");

  property p_write_sel;
    @(posedge clk_sys) disable iff (!nrst)
    exec_write && !mid_reset && chan_sel(cmd_word_reg, 0) |=> chan0_code == $past(cmd_data);
  endproperty
  a_write_sel: assert property (p_write_sel) else $error("write missed channel 0");

  property p_shut_single;
    @(posedge clk_sys) disable iff (!nrst)
    exec_shut && !mid_reset && !chan_sel(cmd_word_reg, 1) |=> $stable(sw_shut_reg[1]);
  endproperty
  a_shut_single: assert property (p_shut_single) else $error("other channel shut");

  property p_abort_no_update;
    @(posedge clk_sys) disable iff (!nrst)
    state_reg == ST_EXEC && !cmd_valid_reg && !mid_reset
      |=> $stable(chan0_code) && $stable(chan1_code);
  endproperty
  a_abort_no_update: assert property (p_abort_no_update) else $error("abort updated");

  property p_idle_no_update;
    @(posedge clk_sys) disable iff (!nrst)
    state_reg == ST_IDLE && !mid_reset |=> $stable(chan1_code);
  endproperty
  a_idle_no_update: assert property (p_idle_no_update) else $error("update when idle");

  property p_both_low;
    @(posedge clk_sys) disable iff (!nrst)
    mid_reset && hw_down |=> chan1_code == MID_CODE && !chan1_term_a;
  endproperty
  a_both_low: assert property (p_both_low) else $error("reset ended shutdown");

  property p_cmd_decode;
    @(posedge clk_sys) disable iff (!nrst)
    exec_cycle && cmd_of(cmd_word_reg) == CMD_SHUT && chan_sel(cmd_word_reg, 0) && !mid_reset
      |=> !chan0_term_a ##1 !chan0_term_a;
  endproperty
  a_cmd_decode: assert property (p_cmd_decode) else $error("shutdown command ignored");

  property p_top_short;
    @(posedge clk_sys) disable iff (!nrst)
    chan1_term_a && chan1_code == MAX_CODE
      |-> chan1_wiper < TAP_A_END && chan1_wiper[CODE_W-1:0] == MAX_CODE;
  endproperty
  a_top_short: assert property (p_top_short) else $error("top code not one below A");

  property p_write_wakes;
    @(posedge clk_sys) disable iff (!nrst)
    exec_write && chan_sel(cmd_word_reg, 1) && !hw_down && !mid_reset |=> chan1_term_a;
  endproperty
  a_write_wakes: assert property (p_write_wakes) else $error("write kept shutdown");

  property p_valid_no_abort;
    @(posedge clk_sys) disable iff (!nrst)
    exec_cycle |-> !frame_abort;
  endproperty
  a_valid_no_abort: assert property (p_valid_no_abort) else $error("bad abort");
endmodule

// file: shared/pot_pkg.sv
// Purpose: shared constants for the dual wiper control block
// Assumes: 16-bit frame, command byte first, msb first
// Notes: word bit = command-byte bit + 8
package pot_pkg;
  localparam int N_CHAN = 2;
  localparam int CODE_W = 8;
  localparam int TAP_W = 9;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 4;
  localparam logic [CODE_W-1:0] MID_CODE = 8'h80;
  localparam logic [CODE_W-1:0] ZERO_CODE = 8'h00;
  localparam logic [CODE_W-1:0] MAX_CODE = 8'hff;
  localparam logic [TAP_W-1:0] TAP_B_END = 9'h000;
  localparam logic [TAP_W-1:0] TAP_A_END = 9'h100;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [FRAME_BITS-1:0] WORD_RST = 16'h0000;
  // positions inside the 16-bit frame
  localparam int CMD_HI_BIT = 13;
  localparam int CMD_LO_BIT = 12;
  localparam int CH1_BIT = 9;
  localparam int CH0_BIT = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam int FRAME_MSB = 15;
  // command select values {hi, lo}
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_SHUT = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } exec_state_t;
endpackage

// file: hw/pot_serial_link.sv
// Purpose: serial shift register and frame counter on the serial clock
// Assumes: serial clock only toggles while cs_n is low
// Notes: word and word_ok stand still while cs_n is high
module pot_serial_link import pot_pkg::*; (
  // reset
  input wire logic nrst,
  // serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  output logic so,
  // towards the system clock domain
  output logic [FRAME_BITS-1:0] word,
  output logic word_ok,
  output logic frame_tog
);
  logic [FRAME_BITS-1:0] shift_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_inc;
  logic in_frame_reg;
  logic ok_reg;
  logic tog_reg;
  logic so_reg;

  assign cnt_inc = cnt_reg + CNT_ONE;
  assign word = shift_reg;
  assign word_ok = ok_reg;
  assign frame_tog = tog_reg;
  assign so = so_reg;

  // sample on rising edge, oldest bit falls out the top
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= WORD_RST;
    end else if (!cs_n) begin
      shift_reg <= {shift_reg[FRAME_MSB-1:0], sdi};
    end
  end

  // rising edges in this frame, cleared while deselected
  always_ff @(posedge sck or posedge cs_n or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= CNT_ZERO;
      in_frame_reg <= 1'b0;
    end else if (cs_n) begin
      cnt_reg <= CNT_ZERO;
      in_frame_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_inc;
      in_frame_reg <= 1'b1;
    end
  end

  // ok only when edge count is a multiple of 16; toggle once per frame
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      ok_reg <= 1'b0;
      tog_reg <= 1'b0;
    end else if (!cs_n) begin
      ok_reg <= (cnt_inc == CNT_ZERO);
      if (!in_frame_reg) begin
        tog_reg <= ~tog_reg;
      end
    end
  end

  // daisy-chain output on falling edge, low while deselected
  always_ff @(negedge sck or posedge cs_n or negedge nrst) begin
    if (!nrst) begin
      so_reg <= 1'b0;
    end else if (cs_n) begin
      so_reg <= 1'b0;
    end else begin
      so_reg <= shift_reg[FRAME_MSB];
    end
  end
endmodule

// file: tb/pot_spi_host.sv
// Purpose: serial host model driving frames into the wiper control block
// Assumes: mode 0, clock low and still outside frames, 80 ns clock period
// Notes: data line shows the inverse of its last bit once released
module pot_spi_host (
  // serial pins
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // bits go msb first, command byte ahead of data byte
  // data changes after falling edges, so is read just before rising edges
  task automatic xfer(input logic [31:0] bits, input int n, output logic [15:0] cap);
    cap = 16'h0000;
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      sdi = bits[n-1-i];
      #40;
      if (n == 32 && i >= 16) begin
        cap[31-i] = so;
      end
      sck = 1'b1;
      #40;
      sck = 1'b0;
    end
    #40;
    cs_n = 1'b1;
    sdi = ~sdi;
    // high time well above the minimum between frames
    #100;
  endtask
endmodule

// file: tb/tb_digital_pot_wiper_control.sv
// Purpose: self-checking bench for the dual wiper control block
// Assumes: outputs settle 4 system clocks after a frame, 3 after a pin change
// Notes: waits are fixed counts with margin over those latencies
module tb_digital_pot_wiper_control import pot_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic midscale_reset_n = 1'b1;
  logic hw_powerdown_n = 1'b1;
  logic sck, cs_n, sdi, so, frame_abort;
  logic [CODE_W-1:0] code0, code1;
  logic [TAP_W-1:0] wip0, wip1;
  logic ta0, tb0, ta1, tb1;
  logic [15:0] so_cap;
  int error_cnt = 0;
  int num_checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  pot_spi_host u_pot_spi_host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .so(so));

  digital_pot_wiper_control u_digital_pot_wiper_control (
    .clk_sys(clk_sys), .nrst(nrst), .sck(sck), .cs_n(cs_n), .sdi(sdi), .so(so),
    .midscale_reset_n(midscale_reset_n), .hw_powerdown_n(hw_powerdown_n),
    .chan0_code(code0), .chan0_wiper(wip0), .chan0_term_a(ta0), .chan0_term_b(tb0),
    .chan1_code(code1), .chan1_wiper(wip1), .chan1_term_a(ta1), .chan1_term_b(tb1),
    .frame_abort(frame_abort));

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chan(input int idx, input logic [7:0] code, input logic [8:0] tap,
                      input logic ta, input logic tb_);
    chk(idx ? {1'b0, code1, wip1, ta1, tb1} : {1'b0, code0, wip0, ta0, tb0},
        {1'b0, code, tap, ta, tb_});
  endtask

  task automatic send(input logic [31:0] bits, input int n);
    @(negedge clk_sys);
    u_pot_spi_host.xfer(bits, n, so_cap);
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic pins(input logic rst_n, input logic pd_n);
    @(negedge clk_sys);
    midscale_reset_n = rst_n;
    hw_powerdown_n = pd_n;
    repeat (5) @(negedge clk_sys);
  endtask

  task automatic t_reset;
    chan(0, MID_CODE, 9'h080, 1'b1, 1'b0);
    chan(1, MID_CODE, 9'h080, 1'b1, 1'b0);
    chk({19'h0, frame_abort}, 20'h0);
  endtask

  task automatic t_write;
    send(32'h1100, 16);
    chan(0, ZERO_CODE, TAP_B_END, 1'b1, 1'b0);
    chan(1, MID_CODE, 9'h080, 1'b1, 1'b0);
    send(32'h13ff, 16);
    chan(0, MAX_CODE, 9'h0ff, 1'b1, 1'b0);
    chan(1, MAX_CODE, 9'h0ff, 1'b1, 1'b0);
  endtask

  task automatic t_abort;
    send(32'h0312, 16);
    send(32'h3312, 16);
    chan(1, MAX_CODE, 9'h0ff, 1'b1, 1'b0);
    send(32'h1140, 15);
    chk({19'h0, frame_abort}, 20'h1);
    chan(0, MAX_CODE, 9'h0ff, 1'b1, 1'b0);
    send(32'h1155_1240, 32);
    chk({4'h0, so_cap}, 20'h01155);
    chan(1, 8'h40, 9'h040, 1'b1, 1'b0);
    chk({19'h0, frame_abort}, 20'h0);
  endtask

  task automatic t_shutdown;
    send(32'h2200, 16);
    chan(1, 8'h40, TAP_B_END, 1'b0, 1'b1);
    chan(0, MAX_CODE, 9'h0ff, 1'b1, 1'b0);
    send(32'h1233, 16);
    chan(1, 8'h33, 9'h033, 1'b1, 1'b0);
    send(32'h2100, 16);
    chan(0, MAX_CODE, TAP_B_END, 1'b0, 1'b1);
    chan(1, 8'h33, 9'h033, 1'b1, 1'b0);
    send(32'h11ff, 16);
    chan(0, MAX_CODE, 9'h0ff, 1'b1, 1'b0);
  endtask

  task automatic t_pins;
    pins(1'b1, 1'b0);
    chan(0, MAX_CODE, TAP_B_END, 1'b0, 1'b1);
    chan(1, 8'h33, TAP_B_END, 1'b0, 1'b1);
    pins(1'b0, 1'b0);
    chan(0, MID_CODE, TAP_B_END, 1'b0, 1'b1);
    pins(1'b1, 1'b1);
    chan(0, MID_CODE, 9'h080, 1'b1, 1'b0);
    chan(1, MID_CODE, 9'h080, 1'b1, 1'b0);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset;
    t_write;
    t_abort;
    t_shutdown;
    t_pins;
    give_verdict;
  end

  // hang guard
  initial begin
    #200000;
    error_cnt++;
    give_verdict;
  end
endmodule
